// File: logic/dmx_pkg.sv
// constants shared by the four-channel dma engine files
// assumes one clock, apb register access, a simple memory port
// Overview of operation
// - destination step code: +1, +2, +4, none
// - source step code uses same encoding
// - width code: byte, halfword, word, reserved
// - pause and re-arbitrate every 2^r transfers
// - no pause when period exceeds run
// - run is count field plus one
// - decode three-bit mode code
// - basic: paused run needs new request
// - auto-request resumes paused run itself
// - ping-pong alternates, stops on mode zero
// - ping-pong signals done per structure
// - memory gather: copy entry, run alternate
// - gather ends when basic entry completes
// - peripheral gather needs request every step
// - done flag per channel, write one clears
// - bus fault flag, write one clears
// - interrupt needs flag and its enable
// - host line ors dma and peripherals
// - high level first, then lower number
// - four independent channels
// - software request bit acts as request
package dmx_pkg;
    // ------------------------------------------------------------
    // sizes and register offsets
    // ------------------------------------------------------------
    localparam int       NCH     = 4;
    localparam int       CH_W    = 2;
    localparam logic [7:0] A_CPTR  = 8'h00;
    localparam logic [7:0] A_CTRL  = 8'h04;
    localparam logic [7:0] A_CHEN  = 8'h08;
    localparam logic [7:0] A_SWREQ = 8'h0c;
    localparam logic [7:0] A_PRIO  = 8'h10;
    localparam logic [7:0] A_ALT   = 8'h14;
    localparam logic [7:0] A_DONE  = 8'h18;
    localparam logic [7:0] A_ERR   = 8'h1c;
    localparam logic [7:0] A_IE    = 8'h20;
    localparam logic [7:0] A_STAT  = 8'h24;
    localparam int       B_EIE   = 8;
    localparam int       B_BUSY  = 8;
    // ------------------------------------------------------------
    // control structure layout in ram
    // ------------------------------------------------------------
    localparam logic [31:0] O_SRC = 32'h0000_0000;
    localparam logic [31:0] O_DST = 32'h0000_0004;
    localparam logic [31:0] O_CTL = 32'h0000_0008;
    localparam logic [31:0] O_ALT = 32'h0000_0040;
    localparam int       CPTR_LO = 7;
    localparam int       F_DINC = 30;
    localparam int       F_DSZ  = 28;
    localparam int       F_SINC = 26;
    localparam int       F_SSZ  = 24;
    localparam int       F_RP   = 14;
    localparam int       F_NM1  = 4;
    localparam int       F_MODE = 0;
    localparam int       NM1_W  = 10;
    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] INC_NONE = 2'h3;
    localparam logic [1:0] SZ_WORD  = 2'h2;
    localparam logic [1:0] SZ_RSV   = 2'h3;
    localparam logic [2:0] MD_STOP  = 3'h0;
    localparam logic [2:0] MD_BASIC = 3'h1;
    localparam logic [2:0] MD_AUTO  = 3'h2;
    localparam logic [2:0] MD_PING  = 3'h3;
    localparam logic [2:0] MD_MSG_P = 3'h4;
    localparam logic [2:0] MD_MSG_A = 3'h5;
    localparam logic [2:0] MD_PSG_P = 3'h6;
    localparam logic [2:0] MD_PSG_A = 3'h7;
    // engine states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CTL  = 7'h02,
        ST_SRC  = 7'h04,
        ST_DST  = 7'h08,
        ST_RD   = 7'h10,
        ST_WR   = 7'h20,
        ST_WB   = 7'h40
    } dmx_st_t;
endpackage : dmx_pkg

// File: logic/dmx_arb.sv
// fixed two-level priority picker for the channel requests
// assumes requests are already gated by channel enables
module dmx_arb
    import dmx_pkg::*;
(
    // requests and levels
    input  wire logic [NCH-1:0]  req,
    input  wire logic [NCH-1:0]  hi,
    // grant
    output logic                 gv,
    output logic [CH_W-1:0]      gch
);
    logic any_hi;  // some high-level channel asks

    // scan downward so the lowest number wins its level
    always_comb begin
        any_hi = |(req & hi);
        gv     = |req;
        gch    = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (req[i] && (hi[i] || !any_hi)) begin
                gch = CH_W'(i);
            end
        end
    end
endmodule : dmx_arb

// File: logic/dmx_addr.sv
// transfer address from end pointer and remaining count
// assumes remaining count is the live count field, or its low two bits on the destination side of a primary gather
module dmx_addr
    import dmx_pkg::*;
(
    // structure fields
    input  wire logic [31:0]      end_ptr,
    input  wire logic [1:0]       inc,
    input  wire logic [NM1_W-1:0] nm1,
    // address of this transfer
    output logic [31:0]           addr
);
    logic [31:0] step;  // distance back from the end

    // last transfer (nm1 zero) lands on the end pointer
    always_comb begin
        if (inc == INC_NONE) begin
            step = 32'h0000_0000;
        end else begin
            step = {22'h0, nm1} << inc;
        end
        addr = end_ptr - step;
    end
endmodule : dmx_addr

// File: logic/dmx_core.sv
// four-channel dma engine: apb registers, structure
// fetch, copy loop, write-back, flags and interrupt
// assumes a memory port that holds off with mem_ack
//
// Chosen here: the register addresses and the APB slave port.
module dmx_core
    import dmx_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // peripheral requests, level
    input  wire logic [NCH-1:0] dma_hw_req,
    input  wire logic        periph_irq_in,
    // memory master port
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic [1:0]       mem_size,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_err,
    // interrupts
    output logic             dma_irq_out,
    output logic             host_irq_line
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]     cptr;   // structure base
        logic            men;    // master enable
        logic [NCH-1:0]  chen;   // channel enables
        logic [NCH-1:0]  hpri;   // high_priority_select
        logic [NCH-1:0]  alt;    // alternate in use
        logic [NCH-1:0]  done;   // done_flag
        logic            berr;   // bus_fault_flag
        logic [NCH-1:0]  ie;     // done enables
        logic            eie;    // fault enable
        logic [NCH-1:0]  swp;    // software_request_bit
        logic [NCH-1:0]  autop;  // self-issued request
        dmx_st_t         fsm;
        logic [CH_W-1:0] ch;     // channel in service
        logic [2:0]      mode;   // mode at fetch
        logic [31:0]     ctl;    // live control word
        logic [31:0]     src;
        logic [31:0]     dst;
        logic [15:0]     cnt;    // transfers this burst
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic            m_req;
        logic            m_we;
        logic [31:0]     m_addr;
        logic [31:0]     m_wdata;
        logic [1:0]      m_size;
        logic            dirq;
        logic            hirq;
    } dmx_state_t;

    dmx_state_t s;       // registered state
    dmx_state_t next_s;  // next state

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [NCH-1:0]   req_v;    // live requests
    logic             gnt_v;
    logic [CH_W-1:0]  gnt_ch;
    logic [31:0]      src_a;
    logic [31:0]      dst_a;
    logic [NM1_W-1:0] c_nm1;
    logic [NM1_W-1:0] d_nm1;    // count seen by the destination side
    logic [3:0]       c_rp;
    logic [15:0]      cnt_inc;
    logic [15:0]      period;
    logic             ack;

    assign c_nm1   = s.ctl[F_NM1 +: NM1_W];
    assign c_rp    = s.ctl[F_RP +: 4];
    assign cnt_inc = 16'(s.cnt + 16'h0001);
    assign period  = 16'h0001 << c_rp;
    assign ack     = s.m_req & mem_ack;
    // a primary gather structure refills the four alternate words on
    // every task, so only the position inside one entry may count
    assign d_nm1   = (s.mode == MD_MSG_P || s.mode == MD_PSG_P)
                   ? {{(NM1_W-2){1'b0}}, c_nm1[1:0]} : c_nm1;

    // a channel asks by hardware, software or itself
    assign req_v = (dma_hw_req | s.swp | s.autop)
                 & s.chen & {NCH{s.men}};

    dmx_arb u_arb (
        .req (req_v),
        .hi  (s.hpri),
        .gv  (gnt_v),
        .gch (gnt_ch)
    );

    dmx_addr u_src (
        .end_ptr (s.src),
        .inc     (s.ctl[F_SINC +: 2]),
        .nm1     (c_nm1),
        .addr    (src_a)
    );

    dmx_addr u_dst (
        .end_ptr (s.dst),
        .inc     (s.ctl[F_DINC +: 2]),
        .nm1     (d_nm1),
        .addr    (dst_a)
    );

    // structure base for a channel and half
    function automatic logic [31:0] base_of(
        input logic [31:0]     cp,
        input logic [CH_W-1:0] c,
        input logic            a
    );
        base_of = cp + {26'h0, c, 4'h0}
                + (a ? O_ALT : 32'h0000_0000);
    endfunction : base_of

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [NCH-1:0] done_set;
        logic           err_set;
        logic           last;
        logic           fin;
        logic [31:0]    bs;
        logic [31:0]    rdv;
        logic           hit;
        done_set = '0;
        err_set  = 1'b0;
        rdv      = 32'h0000_0000;
        hit      = 1'b1;
        next_s   = s;
        last     = (c_nm1 == '0);
        fin      = (s.ctl[F_MODE +: 3] == MD_STOP);
        bs       = base_of(s.cptr, s.ch, s.alt[s.ch]);
        if (ack) begin
            next_s.m_req = 1'b0;
        end
        // bus error aborts the channel in any state
        if (ack && mem_err) begin
            err_set    = 1'b1;
            next_s.fsm = ST_IDLE;
        end else begin
            case (s.fsm)
                // pick the winner and fetch its control word
                ST_IDLE: begin
                    if (gnt_v) begin
                        next_s.ch            = gnt_ch;
                        next_s.swp[gnt_ch]   = 1'b0;
                        next_s.autop[gnt_ch] = 1'b0;
                        next_s.cnt           = 16'h0000;
                        next_s.m_req         = 1'b1;
                        next_s.m_we          = 1'b0;
                        next_s.m_size        = SZ_WORD;
                        next_s.m_addr        = base_of(s.cptr,
                            gnt_ch, s.alt[gnt_ch]) + O_CTL;
                        next_s.fsm           = ST_CTL;
                    end
                end
                ST_CTL: begin
                    if (ack) begin
                        next_s.ctl  = mem_rdata;
                        next_s.mode = mem_rdata[F_MODE +: 3];
                        if (mem_rdata[F_MODE +: 3] == MD_STOP) begin
                            next_s.fsm = ST_IDLE;
                        end else if (mem_rdata[F_SSZ +: 2] == SZ_RSV
                                  || mem_rdata[F_DSZ +: 2] == SZ_RSV) begin
                            // reserved width is refused as a fault
                            err_set    = 1'b1;
                            next_s.fsm = ST_IDLE;
                        end else begin
                            next_s.m_req  = 1'b1;
                            next_s.m_addr = bs + O_SRC;
                            next_s.fsm    = ST_SRC;
                        end
                    end
                end
                ST_SRC: begin
                    if (ack) begin
                        next_s.src    = mem_rdata;
                        next_s.m_req  = 1'b1;
                        next_s.m_addr = bs + O_DST;
                        next_s.fsm    = ST_DST;
                    end
                end
                ST_DST: begin
                    if (ack) begin
                        next_s.dst = mem_rdata;
                        next_s.fsm = ST_RD;
                    end
                end
                // read one item; the request goes out a cycle
                // after entry so addresses see the new count
                ST_RD: begin
                    if (!s.m_req) begin
                        next_s.m_req  = 1'b1;
                        next_s.m_we   = 1'b0;
                        next_s.m_addr = src_a;
                        next_s.m_size = s.ctl[F_SSZ +: 2];
                    end else if (ack) begin
                        next_s.m_req   = 1'b1;
                        next_s.m_we    = 1'b1;
                        next_s.m_addr  = dst_a;
                        next_s.m_wdata = mem_rdata;
                        next_s.m_size  = s.ctl[F_DSZ +: 2];
                        next_s.fsm     = ST_WR;
                    end
                end
                // count the item, then go on, pause or finish
                ST_WR: begin
                    if (ack) begin
                        next_s.cnt = cnt_inc;
                        if (last) begin
                            next_s.ctl[F_MODE +: 3] = MD_STOP;
                        end else begin
                            next_s.ctl[F_NM1 +: NM1_W] =
                                NM1_W'(c_nm1 - 1'b1);
                        end
                        if (!last && cnt_inc != period) begin
                            next_s.fsm = ST_RD;
                        end else begin
                            // pause or end: store count and mode
                            next_s.m_req   = 1'b1;
                            next_s.m_we    = 1'b1;
                            next_s.m_size  = SZ_WORD;
                            next_s.m_addr  = bs + O_CTL;
                            next_s.m_wdata = next_s.ctl;
                            next_s.fsm     = ST_WB;
                        end
                    end
                end
                // decide how this channel carries on
                ST_WB: begin
                    if (ack) begin
                        next_s.fsm = ST_IDLE;
                        case (s.mode)
                            MD_BASIC: begin
                                if (fin) begin
                                    done_set[s.ch] = 1'b1;
                                end
                            end
                            MD_AUTO: begin
                                if (fin) begin
                                    done_set[s.ch] = 1'b1;
                                end else begin
                                    next_s.autop[s.ch] = 1'b1;
                                end
                            end
                            MD_PING: begin
                                if (fin) begin
                                    done_set[s.ch]     = 1'b1;
                                    next_s.alt[s.ch]   = ~s.alt[s.ch];
                                    next_s.autop[s.ch] = 1'b1;
                                end
                            end
                            MD_MSG_P: begin
                                next_s.alt[s.ch]   = 1'b1;
                                next_s.autop[s.ch] = 1'b1;
                            end
                            MD_MSG_A: begin
                                next_s.alt[s.ch]   = ~fin;
                                next_s.autop[s.ch] = 1'b1;
                            end
                            MD_PSG_P: begin
                                next_s.alt[s.ch] = 1'b1;
                            end
                            MD_PSG_A: begin
                                next_s.alt[s.ch] = ~fin;
                            end
                            default: begin
                                next_s.fsm = ST_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    next_s.fsm = ST_IDLE;
                end
            endcase
        end

        // apb read data, sampled in the first access cycle
        case (paddr)
            A_CPTR:  rdv = s.cptr;
            A_CTRL:  rdv = {31'h0, s.men};
            A_CHEN:  rdv = {28'h0, s.chen};
            A_SWREQ: rdv = {28'h0, s.swp};
            A_PRIO:  rdv = {28'h0, s.hpri};
            A_ALT:   rdv = {28'h0, s.alt};
            A_DONE:  rdv = {28'h0, s.done};
            A_ERR:   rdv = {31'h0, s.berr};
            A_IE:    rdv = {23'h0, s.eie, 4'h0, s.ie};
            A_STAT:  rdv = {23'h0, s.fsm != ST_IDLE,
                            6'h0, s.ch};
            default: hit = 1'b0;
        endcase
        next_s.pready  = psel & penable & ~s.pready;
        next_s.pslverr = psel & penable & ~s.pready & ~hit;
        if (psel && penable && !s.pready) begin
            next_s.prdata = hit ? rdv : 32'h0000_0000;
        end

        // writes land at the completing edge; after the
        // engine so a software request is never lost
        if (psel && penable && s.pready && pwrite && !s.pslverr) begin
            case (paddr)
                A_CPTR:  next_s.cptr = {pwdata[31:CPTR_LO],
                                        CPTR_LO'(0)};
                A_CTRL:  next_s.men  = pwdata[0];
                A_CHEN:  next_s.chen = pwdata[NCH-1:0];
                A_SWREQ: next_s.swp  = next_s.swp
                                     | pwdata[NCH-1:0];
                A_PRIO:  next_s.hpri = pwdata[NCH-1:0];
                A_ALT:   next_s.alt  = pwdata[NCH-1:0];
                A_DONE:  next_s.done = s.done
                                     & ~pwdata[NCH-1:0];
                A_ERR:   next_s.berr = s.berr & ~pwdata[0];
                A_IE: begin
                    next_s.ie  = pwdata[NCH-1:0];
                    next_s.eie = pwdata[B_EIE];
                end
                default: next_s.men = s.men;
            endcase
        end

        // hardware sets win over a clear in the same cycle
        next_s.done = next_s.done | done_set;
        next_s.berr = next_s.berr | err_set;
        next_s.dirq = |(next_s.done & next_s.ie)
                    | (next_s.berr & next_s.eie);
        next_s.hirq = next_s.dirq | periph_irq_in;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.fsm <= ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign mem_req       = s.m_req;
    assign mem_we        = s.m_we;
    assign mem_addr      = s.m_addr;
    assign mem_wdata     = s.m_wdata;
    assign mem_size      = s.m_size;
    assign dma_irq_out   = s.dirq;
    assign host_irq_line = s.hirq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic            fin_now;          // live word already stopped
    logic            done_flag_of_ch;  // flag of the channel just served
    logic [CH_W-1:0] ch_d;             // channel of the previous cycle
    assign fin_now = (s.ctl[F_MODE +: 3] == MD_STOP);
    always_ff @(posedge pclk) ch_d <= s.ch;
    assign done_flag_of_ch = s.done[ch_d];

    sequence wb_ok;
        s.fsm == ST_WB && ack && !mem_err;
    endsequence

    chk_done_raise: assert property (
        wb_ok and (s.mode == MD_BASIC) and fin_now
        |=> done_flag_of_ch)
        else $error("done flag not raised at run end");

    chk_irq_gate: assert property (
        dma_irq_out |-> (|(s.done & s.ie) | (s.berr & s.eie)))
        else $error("interrupt without enabled flag");

    chk_host_or: assert property (
        (dma_irq_out || $past(periph_irq_in)) |-> host_irq_line)
        else $error("host line missing a source");

    chk_fault_set: assert property (
        ack && mem_err |=> s.berr && s.fsm == ST_IDLE)
        else $error("bus fault not flagged");

    chk_dst_fixed: assert property (
        s.fsm == ST_WR && s.ctl[F_DINC +: 2] == INC_NONE
        |-> mem_addr == s.dst)
        else $error("fixed destination moved");

    chk_src_word: assert property (
        s.fsm == ST_RD && s.m_req && s.ctl[F_SINC +: 2] == 2'h2
        |-> mem_addr == s.src - {20'h0, c_nm1, 2'h0})
        else $error("source word step wrong");

    chk_pause_wb: assert property (
        s.fsm == ST_WR && ack && !mem_err && cnt_inc == period
        |=> s.fsm == ST_WB ##[1:1000] s.fsm == ST_IDLE)
        else $error("no pause at arbitration period");

    chk_auto_go: assert property (
        wb_ok and (s.mode == MD_AUTO) and !fin_now
        |=> s.autop[ch_d])
        else $error("auto mode did not resume");

    chk_prio_hi: assert property (
        s.fsm == ST_IDLE && |(req_v & s.hpri)
        |=> s.hpri[s.ch] && s.fsm == ST_CTL)
        else $error("low level served before high");
endmodule : dmx_core

// File: tb/dmx_ram.sv
// ram model on the engine memory port
// assumes word traffic; acks after a random wait
module dmx_ram (
    // engine side
    input  wire logic        pclk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    // answer
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             mem_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255]; // word store
    int          dly = 0;     // wait left
    logic        fault = 1'b0; // bench raises it to inject bus faults
    assign mem_err = fault & mem_ack; // the fault rides on the ack
    always @(posedge pclk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata; // stale data never looks valid
        if (mem_req && mem_ack !== 1'b1) begin
            if (dly == 0) begin
                mem_ack <= 1'b1;
                if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
                else mem_rdata <= mem[mem_addr[9:2]];
                dly = $urandom_range(2);
            end else dly--;
        end
    end
endmodule : dmx_ram

// File: tb/testbench.sv
// bench for the dma engine: apb master, ram model
// assumes structure base 0 and word-sized copies
module testbench
    import dmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pirq;
    logic mreq, mwe, mack, merr, irq, hirq, e;
    logic [7:0]  paddr;
    logic [3:0]  hwreq;
    logic [1:0]  msz;
    logic [31:0] pwdata, prdata, maddr, mwd, mrd, q, ctl;
    logic [31:0] src [4];
    int mismatches = 0, total_checks = 0, cyc = 0;
    dmx_core dmx_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_hw_req(hwreq), .periph_irq_in(pirq), .mem_req(mreq),
        .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_size(msz), .mem_ack(mack),
        .mem_rdata(mrd), .mem_err(merr), .dma_irq_out(irq), .host_irq_line(hirq));
    dmx_ram dmx_ram_inst (.pclk(pclk), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
        .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd), .mem_err(merr));
    // apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // hang guard, far above a normal run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, pirq, hwreq, paddr, pwdata} = '0;
        void'($urandom(32'h0000_252b));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, A_CPTR, 32'h0000_0000);
        apb(1'b1, A_CTRL, 32'h0000_0001);
        apb(1'b1, A_CHEN, 32'h0000_0003);
        apb(1'b1, A_IE, 32'h0000_000f);
        apb(1'b1, A_PRIO, 32'h0000_0002);
        // ch0 basic by software, no pause; ch1 auto by hardware, pauses every 2
        for (int c = 0; c < 2; c++) begin
            ctl = {8'haa, 6'h0, (c ? 4'h1 : 4'h4), 10'h3, 1'b0, (c ? MD_AUTO : MD_BASIC)};
            dmx_ram_inst.mem[c*4]   = 32'h0000_010c + c * 64;
            dmx_ram_inst.mem[c*4+1] = 32'h0000_020c + c * 64;
            dmx_ram_inst.mem[c*4+2] = ctl;
            for (int i = 0; i < 4; i++) begin
                src[i] = $urandom();
                dmx_ram_inst.mem[64+c*16+i] = src[i];
            end
            if (c == 0) apb(1'b1, A_SWREQ, 32'h0000_0001);
            else hwreq <= 4'h2;
            do apb(1'b0, A_DONE, 32'h0000_0000); while (q[c] !== 1'b1);
            hwreq <= 4'h0;
            cmp(32'(irq), 32'h0000_0001);
            for (int i = 0; i < 4; i++) cmp(dmx_ram_inst.mem[128+c*16+i], src[i]);
            cmp(dmx_ram_inst.mem[c*4+2], {ctl[31:14], 14'h0});
            apb(1'b1, A_DONE, 32'h0000_0001 << c);
            apb(1'b0, A_DONE, 32'h0000_0000);
            cmp(q, 32'h0000_0000);
        end
        // ch0 gather of two tasks: memory by software, then peripheral by hardware
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, A_ALT, 32'h0000_0000);
            dmx_ram_inst.mem[0] = 32'h0000_031c;
            dmx_ram_inst.mem[1] = 32'h0000_004c;
            dmx_ram_inst.mem[2] = {8'haa, 6'h0, 4'h2, 10'h7, 1'b0, (m ? MD_PSG_P : MD_MSG_P)};
            for (int k = 0; k < 2; k++) begin
                dmx_ram_inst.mem[192+k*4]   = 32'h0000_0144 + k * 8;
                dmx_ram_inst.mem[192+k*4+1] = 32'h0000_02c4 + m * 32 + k * 8;
                ctl = {8'haa, 6'h0, 4'h4, 10'h1, 1'b0, (k ? MD_BASIC : (m ? MD_PSG_A : MD_MSG_A))};
                dmx_ram_inst.mem[192+k*4+2] = ctl;
            end
            if (m == 0) apb(1'b1, A_SWREQ, 32'h0000_0001);
            else hwreq <= 4'h1;
            do apb(1'b0, A_DONE, 32'h0000_0000); while (q[0] !== 1'b1);
            hwreq <= 4'h0;
            for (int i = 0; i < 4; i++) cmp(dmx_ram_inst.mem[176+m*8+i], src[i]);
            apb(1'b1, A_DONE, 32'h0000_0001);
        end
        // a faulting bus access must raise the fault flag, write one clears it
        dmx_ram_inst.fault = 1'b1;
        apb(1'b1, A_SWREQ, 32'h0000_0001);
        do apb(1'b0, A_ERR, 32'h0000_0000); while (q[0] !== 1'b1);
        dmx_ram_inst.fault = 1'b0;
        cmp(q, 32'h0000_0001);
        apb(1'b1, A_ERR, 32'h0000_0001);
        apb(1'b0, A_ERR, 32'h0000_0000);
        cmp(q, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        cmp(32'(e), 32'h0000_0001);
        pirq <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp(32'(hirq), 32'h0000_0001);
        summarize();
    end
endmodule : testbench
